// ==== verilog/smdsp_pkg.sv ====
// Shared constants and types for the secure memory dual serial port.
package smdsp_pkg;

  // ----------------------------------------
  // Asynchronous bit timing
  // ----------------------------------------
  // Carrier periods in one bit_period_unit after a card reset.
  localparam logic [8:0] ETU_DEFAULT_CLKS = 9'h174;
  // Fastest carrier and highest negotiated baud rate.
  localparam int CARRIER_MAX_HZ = 5_000_000;
  localparam int BAUD_MAX = 153_600;
  // Shortest bit_period_unit that keeps the rate at or below the limit.
  localparam logic [8:0] ETU_MIN_CLKS = 9'((CARRIER_MAX_HZ + BAUD_MAX - 1) / BAUD_MAX);

  // ----------------------------------------
  // Character framing and answer-to-reset
  // ----------------------------------------
  localparam logic [3:0] ATR_BYTES = 4'h8;
  localparam logic [3:0] BIT_PARITY = 4'h9;
  localparam logic [3:0] BIT_ERR_SAMPLE = 4'hA;
  localparam logic [3:0] BIT_GUARD_END = 4'hB;
  localparam logic [3:0] BIT_REPEAT = 4'hC;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ----------------------------------------
  // States and carriers
  // ----------------------------------------
  typedef enum logic [1:0] {
    AS_OFF = 2'h0,
    AS_IDLE = 2'h1,
    AS_TX = 2'h3,
    AS_RX = 2'h2
  } smdsp_async_e;

  typedef enum logic [2:0] {
    SY_IDLE = 3'h0,
    SY_ADDR = 3'h1,
    SY_ADEC = 3'h3,
    SY_ACK = 3'h2,
    SY_WR = 3'h6,
    SY_RD = 3'h7,
    SY_RACK = 3'h5,
    SY_RLOAD = 3'h4
  } smdsp_sync_e;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } smdsp_byte_s;

endpackage

// ==== verilog/smdsp_port.sv ====
// Pin-level serial front end: smart-card character link and 2-wire bus slave.
// Notes on behaviour
// - In async mode each bit lasts one bit_period_unit, 372 carrier clocks after card reset.
// - In sync mode incoming data is sampled on the clock's rising edge.
// - In sync mode outgoing data changes after the clock's falling edge.
// - Releasing card reset sends the 64-bit answer-to-reset value asynchronously.
// - Reset input is pulled high internally so sync use works unconnected.
// - No answer-to-reset is ever produced in synchronous mode.
// - The data pin is open-drain: pulled low or released, never driven high.
// - The negotiated bit_period_unit may be shortened down to the 153,600 baud limit.
// - On the 2-wire bus the device answers only to its own address.
// - Bus clock runs up to 1.0 MHz; host keeps within that rate.
// - Card characters follow the T=0 framing with parity error signalling.
module smdsp_port
  import smdsp_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic link_clk_pin,
  input wire logic card_rst_pin,
  input wire logic io_in,
  output logic io_out,
  output logic io_oe,
  output logic rst_pull_up,
  input wire logic [63:0] atr_value,
  input wire logic [3:0] device_addr,
  input wire logic [8:0] etu_cfg,
  input wire logic etu_apply,
  input wire logic [7:0] tx_byte_data,
  input wire logic tx_byte_valid,
  output logic tx_byte_ready,
  output smdsp_byte_s rx_byte,
  output logic rx_parity_err,
  output logic async_mode
);

  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  logic rst_meta, rst_n_s;
  logic [2:0] pin_m, pin_s, pin_d;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n_s <= rst_meta;
    end
  end

  // Idle levels are high: the reset pin floats high through its pull-up.
  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      pin_m <= 3'h7;
      pin_s <= 3'h7;
      pin_d <= 3'h7;
    end else begin
      pin_m <= {card_rst_pin, io_in, link_clk_pin};
      pin_s <= pin_m;
      pin_d <= pin_s;
    end
  end

  assign rst_pull_up = 1'b1;
  assign io_out = 1'b0;

  logic clk_s, io_s, card_rst_s, clk_rise, clk_fall, io_fall, start_c, stop_c;
  assign clk_s = pin_s[0];
  assign io_s = pin_s[1];
  assign card_rst_s = pin_s[2];
  // Sampling at 100 MHz resolves every edge of a bus clock up to 1.0 MHz.
  assign clk_rise = pin_s[0] & ~pin_d[0];
  assign clk_fall = ~pin_s[0] & pin_d[0];
  assign io_fall = ~pin_s[1] & pin_d[1];
  // Data moving while the clock stays high marks start or stop.
  assign start_c = clk_s & pin_d[0] & io_fall;
  assign stop_c = clk_s & pin_d[0] & pin_s[1] & ~pin_d[1];

  // Even-parity character: start bit, eight data bits LSB first, parity.
  function automatic logic [9:0] make_frame(input logic [7:0] b);
    make_frame = {^b, b, 1'b0};
  endfunction

  // ----------------------------------------
  // Engine state
  // ----------------------------------------
  smdsp_async_e as_state, next_as_state;
  smdsp_sync_e sy_state, next_sy_state;
  logic [8:0] bit_period_unit, next_etu, clk_cnt, next_clk_cnt;
  logic [3:0] bit_idx, next_bit_idx, atr_left, next_atr_left;
  logic [9:0] tx_frame, next_tx_frame;
  logic [8:0] rx_shift, next_rx_shift;
  logic [63:0] atr_shift, next_atr_shift;
  logic [7:0] sy_shift, next_sy_shift, sy_tx, next_sy_tx;
  logic [2:0] sy_cnt, next_sy_cnt;
  logic line_err, next_line_err, addr_hit, next_addr_hit, rw, next_rw;
  logic drive_low, next_drive_low, next_async_mode, next_rx_parity_err;
  smdsp_byte_s next_rx_byte;
  logic tick_mid, tick_end;
  logic [7:0] in_byte;
  logic [8:0] rx_new;

  assign tick_mid = clk_rise && (clk_cnt == {1'b0, bit_period_unit[8:1]});
  assign tick_end = clk_rise && (clk_cnt == bit_period_unit - 9'h001);
  assign in_byte = {sy_shift[6:0], io_s};
  assign rx_new = {io_s, rx_shift[8:1]};
  assign io_oe = drive_low;

  always_comb begin
    next_as_state = as_state;
    next_sy_state = sy_state;
    next_etu = bit_period_unit;
    next_clk_cnt = clk_cnt;
    next_bit_idx = bit_idx;
    next_atr_left = atr_left;
    next_tx_frame = tx_frame;
    next_rx_shift = rx_shift;
    next_atr_shift = atr_shift;
    next_sy_shift = sy_shift;
    next_sy_tx = sy_tx;
    next_sy_cnt = sy_cnt;
    next_line_err = line_err;
    next_addr_hit = addr_hit;
    next_rw = rw;
    next_drive_low = drive_low;
    next_async_mode = async_mode;
    next_rx_byte = '{valid: 1'b0, data: rx_byte.data};
    next_rx_parity_err = 1'b0;
    tx_byte_ready = 1'b0;
    if (etu_apply) begin
      next_etu = (etu_cfg < ETU_MIN_CLKS) ? ETU_MIN_CLKS : etu_cfg;
    end
    if (!card_rst_s) begin
      // Card reset held: the smart-card protocol owns the pins from now on.
      next_async_mode = 1'b1;
      next_as_state = AS_OFF;
      next_etu = ETU_DEFAULT_CLKS;
      next_drive_low = 1'b0;
      next_atr_left = 4'h0;
      next_sy_state = SY_IDLE;
    end else if (async_mode) begin
      if (clk_rise) begin
        next_clk_cnt = (clk_cnt == bit_period_unit - 9'h001) ? 9'h000 : clk_cnt + 9'h001;
      end
      case (as_state)
        AS_OFF: begin
          next_as_state = AS_IDLE;
          next_atr_left = ATR_BYTES;
          next_atr_shift = atr_value;
        end
        AS_IDLE: begin
          if (atr_left != 4'h0) begin
            next_tx_frame = make_frame(atr_shift[63:56]);
            next_atr_shift = {atr_shift[55:0], 8'h00};
            next_atr_left = atr_left - 4'h1;
          end else if (!io_fall && tx_byte_valid) begin
            tx_byte_ready = 1'b1;
            next_tx_frame = make_frame(tx_byte_data);
          end
          if (atr_left != 4'h0 || (!io_fall && tx_byte_valid)) begin
            next_as_state = AS_TX;
            next_clk_cnt = 9'h000;
            next_bit_idx = 4'h0;
            next_line_err = 1'b0;
            next_drive_low = 1'b1;
          end else if (io_fall) begin
            next_as_state = AS_RX;
            next_clk_cnt = 9'h000;
            next_bit_idx = 4'h0;
            next_line_err = 1'b0;
          end
        end
        AS_TX: begin
          if (tick_end) begin
            next_bit_idx = bit_idx + 4'h1;
            if (bit_idx < BIT_PARITY) begin
              next_drive_low = ~tx_frame[bit_idx + 4'h1];
            end else if (bit_idx == BIT_PARITY) begin
              next_drive_low = 1'b0;
            end else if (bit_idx == BIT_ERR_SAMPLE) begin
              next_line_err = ~io_s;
            end else if (bit_idx == BIT_GUARD_END && !line_err) begin
              next_as_state = AS_IDLE;
            end else if (bit_idx == BIT_REPEAT) begin
              next_bit_idx = 4'h0;
              next_line_err = 1'b0;
              next_drive_low = 1'b1;
            end
          end
        end
        AS_RX: begin
          if (tick_mid) begin
            next_bit_idx = bit_idx + 4'h1;
            if (bit_idx == 4'h0) begin
              if (io_s) begin
                next_as_state = AS_IDLE;
              end
            end else if (bit_idx <= BIT_PARITY) begin
              next_rx_shift = rx_new;
              if (bit_idx == BIT_PARITY) begin
                if (^rx_new) begin
                  next_line_err = 1'b1;
                  next_rx_parity_err = 1'b1;
                end else begin
                  next_rx_byte = '{valid: 1'b1, data: rx_new[7:0]};
                end
              end
            end else if (bit_idx == BIT_ERR_SAMPLE) begin
              next_drive_low = line_err;
            end else begin
              next_drive_low = 1'b0;
              next_as_state = AS_IDLE;
            end
          end
        end
        default: next_as_state = AS_OFF;
      endcase
    end else if (start_c) begin
      next_sy_state = SY_ADDR;
      next_sy_cnt = 3'h0;
      next_drive_low = 1'b0;
      next_addr_hit = 1'b0;
    end else if (stop_c) begin
      next_sy_state = SY_IDLE;
      next_drive_low = 1'b0;
    end else begin
      case (sy_state)
        SY_ADDR, SY_WR: begin
          if (clk_rise) begin
            next_sy_shift = in_byte;
            next_sy_cnt = sy_cnt + 3'h1;
            if (sy_cnt == LAST_BIT) begin
              next_sy_state = SY_ADEC;
              if (sy_state == SY_ADDR) begin
                next_addr_hit = (in_byte[7:4] == device_addr);
                next_rw = in_byte[0];
              end else begin
                next_rx_byte = '{valid: 1'b1, data: in_byte};
              end
            end
          end
        end
        SY_ADEC: begin
          if (clk_fall) begin
            next_drive_low = addr_hit;
            next_sy_state = addr_hit ? SY_ACK : SY_IDLE;
          end
        end
        SY_ACK, SY_RLOAD: begin
          if (clk_fall) begin
            next_sy_cnt = 3'h0;
            if (sy_state == SY_ACK && !rw) begin
              next_drive_low = 1'b0;
              next_sy_state = SY_WR;
            end else begin
              tx_byte_ready = 1'b1;
              next_sy_tx = {tx_byte_data[6:0], 1'b0};
              next_drive_low = ~tx_byte_data[7];
              next_sy_state = SY_RD;
            end
          end
        end
        SY_RD: begin
          if (clk_fall) begin
            next_sy_cnt = sy_cnt + 3'h1;
            if (sy_cnt == LAST_BIT) begin
              next_drive_low = 1'b0;
              next_sy_state = SY_RACK;
            end else begin
              next_drive_low = ~sy_tx[7];
              next_sy_tx = {sy_tx[6:0], 1'b0};
            end
          end
        end
        SY_RACK: begin
          if (clk_rise) begin
            next_sy_state = io_s ? SY_IDLE : SY_RLOAD;
          end
        end
        default: next_sy_state = SY_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      as_state <= AS_OFF;
      sy_state <= SY_IDLE;
      bit_period_unit <= ETU_DEFAULT_CLKS;
      clk_cnt <= 9'h000;
      bit_idx <= 4'h0;
      atr_left <= 4'h0;
      tx_frame <= 10'h3FF;
      rx_shift <= 9'h000;
      atr_shift <= 64'h0;
      sy_shift <= 8'h00;
      sy_tx <= 8'h00;
      sy_cnt <= 3'h0;
      line_err <= 1'b0;
      addr_hit <= 1'b0;
      rw <= 1'b0;
      drive_low <= 1'b0;
      async_mode <= 1'b0;
      rx_byte <= '{valid: 1'b0, data: 8'h00};
      rx_parity_err <= 1'b0;
    end else begin
      as_state <= next_as_state;
      sy_state <= next_sy_state;
      bit_period_unit <= next_etu;
      clk_cnt <= next_clk_cnt;
      bit_idx <= next_bit_idx;
      atr_left <= next_atr_left;
      tx_frame <= next_tx_frame;
      rx_shift <= next_rx_shift;
      atr_shift <= next_atr_shift;
      sy_shift <= next_sy_shift;
      sy_tx <= next_sy_tx;
      sy_cnt <= next_sy_cnt;
      line_err <= next_line_err;
      addr_hit <= next_addr_hit;
      rw <= next_rw;
      drive_low <= next_drive_low;
      async_mode <= next_async_mode;
      rx_byte <= next_rx_byte;
      rx_parity_err <= next_rx_parity_err;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n_s);

  property p_bit_length;
    as_state == AS_TX && $past(as_state) == AS_TX && $changed(io_oe)
      |-> clk_cnt == 9'h000 && $past(clk_cnt) == $past(bit_period_unit) - 9'h001;
  endproperty
  a_bit_length: assert property (p_bit_length) else $error("bit edge off unit boundary");

  property p_sync_sample;
    !async_mode && $changed(sy_shift) |-> $past(clk_rise);
  endproperty
  a_sync_sample: assert property (p_sync_sample) else $error("sync input taken off rise");

  property p_sync_drive;
    !async_mode && $past(!async_mode) && $changed(io_oe)
      |-> $past(clk_fall) || $past(start_c) || $past(stop_c);
  endproperty
  a_sync_drive: assert property (p_sync_drive) else $error("sync output moved off fall");

  property p_atr_load;
    async_mode && $rose(card_rst_s) |=> atr_left == ATR_BYTES && as_state == AS_IDLE;
  endproperty
  a_atr_load: assert property (p_atr_load) else $error("reset answer not started");

  property p_pull_up;
    rst_pull_up;
  endproperty
  a_pull_up: assert property (p_pull_up) else $error("reset pull-up off");

  property p_no_sync_atr;
    !async_mode |-> atr_left == 4'h0 && as_state == AS_OFF;
  endproperty
  a_no_sync_atr: assert property (p_no_sync_atr) else $error("reset answer in sync mode");

  property p_open_drain;
    io_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");

  property p_etu_floor;
    bit_period_unit >= ETU_MIN_CLKS;
  endproperty
  a_etu_floor: assert property (p_etu_floor) else $error("bit unit below rate limit");

  property p_addr_only;
    sy_state == SY_ACK && $past(sy_state) == SY_ADEC |-> addr_hit && io_oe;
  endproperty
  a_addr_only: assert property (p_addr_only) else $error("ack without address match");

  property p_parity_signal;
    as_state == AS_RX && line_err && tick_mid && bit_idx == BIT_ERR_SAMPLE |=> io_oe;
  endproperty
  a_parity_signal: assert property (p_parity_signal) else $error("parity error not signalled");

endmodule // smdsp_port

// ==== test/smdsp_host_model.sv ====
// Host-side model driving the shared clock and data pins as bus master or card reader.
module smdsp_host_model (
  output logic lclk,
  output logic host_low,
  input wire logic io_wire
);
  timeunit 1ns;
  timeprecision 100ps;
  logic car_run = 1'b0;

  initial begin
    lclk = 1'b1;
    host_low = 1'b0;
  end

  // ----------------------------------------
  // Card reader
  // ----------------------------------------
  // The carrier runs freely for the whole card session.
  always begin
    #62.5;
    if (car_run) lclk = ~lclk;
  end

  // Samples eight data bits and parity at mid-unit; also measures the start bit.
  task automatic card_get(input int bit_period_unit, output logic [8:0] bits, output int low_len);
    int i;
    low_len = 0;
    bits = 9'h000;
    @(negedge io_wire);
    for (i = 1; i <= bit_period_unit * 10; i++) begin
      @(posedge lclk);
      if (low_len == 0 && io_wire) low_len = i;
      if (i > bit_period_unit && i % bit_period_unit == bit_period_unit / 2) bits = {io_wire, bits[8:1]};
    end
  endtask

  // Error signal from mid guard unit for one unit, asking for a repeat.
  task automatic card_nak(input int bit_period_unit);
    repeat (bit_period_unit / 2) @(posedge lclk);
    host_low = 1'b1;
    repeat (bit_period_unit) @(posedge lclk);
    host_low = 1'b0;
  endtask

  task automatic card_put(input int bit_period_unit, input logic [8:0] bits, output logic err_low);
    int i;
    repeat (3 * bit_period_unit) @(posedge lclk);
    host_low = 1'b1;
    for (i = 0; i < 9; i++) begin
      repeat (bit_period_unit) @(posedge lclk);
      host_low = ~bits[i];
    end
    repeat (bit_period_unit) @(posedge lclk);
    host_low = 1'b0;
    repeat (bit_period_unit) @(posedge lclk);
    err_low = ~io_wire;
    repeat (bit_period_unit) @(posedge lclk);
  endtask

  // ----------------------------------------
  // Two-wire bus master at 1 MHz
  // ----------------------------------------
  task automatic tw_start();
    #250 host_low = 1'b1;
    #250 lclk = 1'b0;
  endtask

  task automatic tw_stop();
    #250 host_low = 1'b1;
    #250 lclk = 1'b1;
    #250 host_low = 1'b0;
    #250;
  endtask

  // Nine bits MSB first; the line is sampled early and late in each high phase.
  task automatic tw_byte(input logic [8:0] tx, output logic [8:0] rx, output logic stable);
    int i;
    logic early;
    stable = 1'b1;
    for (i = 8; i >= 0; i--) begin
      #250 host_low = ~tx[i];
      #250 lclk = 1'b1;
      #20 early = io_wire;
      #430 rx[i] = io_wire;
      stable = stable & (early === rx[i]);
      #50 lclk = 1'b0;
    end
  endtask
endmodule // smdsp_host_model

// ==== test/smdsp_port_bench.sv ====
// Self-checking bench for the dual serial port: bus transfers, answer-to-reset, card chars.
module smdsp_port_bench
  import smdsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic card_rst_pin = 1'b1;
  logic [63:0] atr_value = 64'h0;
  logic [3:0] device_addr = 4'h0;
  logic [8:0] etu_cfg = 9'h000;
  logic etu_apply = 1'b0;
  logic [7:0] tx_byte_data = 8'h00;
  logic tx_byte_valid = 1'b0;
  logic lclk;
  logic host_low;
  wire logic io_wire;
  logic io_out;
  logic io_oe;
  logic rst_pull_up;
  logic tx_byte_ready;
  smdsp_byte_s rx_byte;
  logic rx_parity_err;
  logic async_mode;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int exp_q[$];

  assign io_wire = ~(io_oe | host_low);
  always #5 core_clk = ~core_clk;

  smdsp_port u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .link_clk_pin(lclk), .card_rst_pin(card_rst_pin),
    .io_in(io_wire), .io_out(io_out), .io_oe(io_oe), .rst_pull_up(rst_pull_up),
    .atr_value(atr_value), .device_addr(device_addr), .etu_cfg(etu_cfg), .etu_apply(etu_apply),
    .tx_byte_data(tx_byte_data), .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
    .rx_byte(rx_byte), .rx_parity_err(rx_parity_err), .async_mode(async_mode)
  );

  smdsp_host_model u_host (.lclk(lclk), .host_low(host_low), .io_wire(io_wire));

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  function automatic logic [15:0] pop_exp();
    if (exp_q.size() == 0) return 16'hFFFF;
    return 16'(exp_q.pop_front());
  endfunction

  task automatic conclude();
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Every received byte or parity error is matched against the expected queue.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (rx_byte.valid === 1'b1 || rx_parity_err === 1'b1) begin
      chk_val("received", pop_exp(),
              rx_parity_err === 1'b1 ? 16'h0100 : {8'h00, rx_byte.data});
    end
    if (reset_n === 1'b1 && io_out !== 1'b0) chk_flag("io_out", 1'b0, io_out);
    if (cyc == 150000) begin
      error_cnt++;
      conclude();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [8:0] got;
    logic [7:0] d;
    logic st;
    logic e;
    int len;
    int bit_period_unit;
    void'($urandom(98979));
    device_addr = 4'($urandom);
    atr_value = {$urandom, $urandom} | 64'h0101_0101_0101_0101;
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (100) @(negedge core_clk);
    chk_flag("pull_up", 1'b1, rst_pull_up);
    chk_flag("async_mode", 1'b0, async_mode);
    chk_flag("idle_io", 1'b0, io_oe);
    d = 8'($urandom);
    exp_q.push_back(d);
    u_host.tw_start();
    u_host.tw_byte({device_addr, 5'h01}, got, st);
    chk_flag("addr_ack", 1'b0, got[0]);
    u_host.tw_byte({d, 1'b1}, got, st);
    chk_flag("data_ack", 1'b0, got[0]);
    u_host.tw_stop();
    u_host.tw_start();
    u_host.tw_byte({device_addr ^ 4'h9, 5'h01}, got, st);
    chk_flag("foreign_addr", 1'b1, got[0]);
    u_host.tw_byte({d, 1'b1}, got, st);
    chk_flag("foreign_data", 1'b1, got[0]);
    u_host.tw_stop();
    @(negedge core_clk);
    tx_byte_data = 8'($urandom);
    u_host.tw_start();
    u_host.tw_byte({device_addr, 5'h03}, got, st);
    chk_flag("read_ack", 1'b0, got[0]);
    for (int i = 0; i < 2; i++) begin
      repeat (10) @(negedge core_clk);
      d = tx_byte_data;
      tx_byte_data = 8'($urandom);
      u_host.tw_byte({8'hFF, i[0]}, got, st);
      chk_val("read_byte", {8'h00, d}, {8'h00, got[8:1]});
      chk_flag("read_stable", 1'b1, st);
    end
    u_host.tw_stop();
    u_host.car_run = 1'b1;
    @(negedge core_clk);
    card_rst_pin = 1'b0;
    repeat (200) @(negedge core_clk);
    chk_flag("async_mode", 1'b1, async_mode);
    card_rst_pin = 1'b1;
    for (int i = 0; i < 8; i++) begin
      bit_period_unit = (i == 0) ? 372 : int'(ETU_MIN_CLKS);
      u_host.card_get(bit_period_unit, got, len);
      d = atr_value[63 - 8 * i -: 8];
      chk_val("atr", {7'h00, ^d, d}, {7'h00, got});
      chk_flag("bit_len", 1'b1, len >= bit_period_unit && len <= bit_period_unit + 1);
      if (i == 0) begin
        // Change the unit only once the device has seen the parity boundary tick.
        @(posedge u_host.lclk);
        repeat (5) @(negedge core_clk);
        etu_cfg = 9'h014;
        etu_apply = 1'b1;
        @(negedge core_clk);
        etu_apply = 1'b0;
      end
    end
    d = 8'($urandom);
    @(negedge core_clk);
    tx_byte_data = d;
    fork
      u_host.card_get(bit_period_unit, got, len);
      begin
        tx_byte_valid = 1'b1;
        do @(negedge core_clk); while (tx_byte_ready !== 1'b1);
        @(negedge core_clk);
        tx_byte_valid = 1'b0;
      end
    join
    chk_val("tx", {7'h00, ^d, d}, {7'h00, got});
    u_host.card_nak(bit_period_unit);
    u_host.card_get(bit_period_unit, got, len);
    chk_val("tx_again", {7'h00, ^d, d}, {7'h00, got});
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      exp_q.push_back((i == 0) ? {8'h00, d} : 16'h0100);
      u_host.card_put(bit_period_unit, {^d ^ i[0], d}, e);
      chk_flag("err_signal", i[0], e);
    end
    repeat (100) @(negedge core_clk);
    chk_val("pending", 16'h0000, 16'(exp_q.size()));
    conclude();
  end
endmodule // smdsp_port_bench
